// ### hdl/sarsr_dev.sv
// Purpose: Converter end: sampling, bit-serial conversion, readout
// Assumes: Select and serial clock are synchronous to core_clk
// Notes:   One sample is taken from the buffer per conversion
//
// What this block does
// - Select input is active low
// - Select falling starts a new conversion
// - Bits shift only while select held low
// - Result pin changes on serial clock fall
// - Four zeros then twelve result bits
// - Result sent most significant bit first
// - Result coded as twos complement
// - Serial clock falls advance the approximation
// - Code steps all-ones to zero at midscale
// - Positive end saturates at largest code
// - Negative end sits at smallest code
// - Host keeps quiet gap before reselecting

`timescale 1ns/1ps

module sarsr_dev #(
	parameter int SMP_W = sarsr_pkg::SMP_W,
	parameter int DEPTH = sarsr_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic                           core_clk,
	input  wire logic                           nrst,
	// Link
	sarsr_link_if.dev                           link,
	// Sample source, signed differential input
	input  wire logic signed [SMP_W-1:0]        smp_data,
	input  wire logic                           smp_valid,
	output logic                                smp_ready,
	// Result seen by the converter itself
	output logic [sarsr_pkg::CODE_W-1:0]        code_q,
	output logic                                code_valid_q,
	output logic                                abort_q,
	output logic                                underrun_q
);

	// ------------------------------------------------------------
	// Types and helpers
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_SHIFT = 2'b01,
		ST_DONE  = 2'b10
	} sarsr_dev_st_t;

	// Clamp input to the twelve-bit code range
	function automatic logic [sarsr_pkg::CODE_W-1:0] sat_code(input logic signed [SMP_W-1:0] v);
		logic signed [SMP_W-1:0] hi;
		logic signed [SMP_W-1:0] lo;
		hi = SMP_W'(signed'({1'b0, sarsr_pkg::CODE_MAX}));
		lo = -SMP_W'(signed'({1'b0, sarsr_pkg::CODE_SIGN}));
		if (v > hi) begin
			sat_code = sarsr_pkg::CODE_MAX;
		end else if (v < lo) begin
			sat_code = sarsr_pkg::CODE_MIN;
		end else begin
			sat_code = v[sarsr_pkg::CODE_W-1:0];
		end
	endfunction

	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	sarsr_dev_st_t                     st_q;
	sarsr_dev_st_t                     st_d;
	logic                              sel_prev_q;
	logic                              sclk_prev_q;
	logic                              sel_fall;
	logic                              sel_rise;
	logic                              sclk_fall;
	logic [sarsr_pkg::CNT_W-1:0]       cnt_q;
	logic [sarsr_pkg::CNT_W-1:0]       cnt_next;
	logic [sarsr_pkg::CODE_W-1:0]      target_q;   // Offset binary sample
	logic [sarsr_pkg::CODE_W-1:0]      sar_q;
	logic [sarsr_pkg::CODE_W-1:0]      trial;
	logic [sarsr_pkg::CODE_W-1:0]      bit_mask;
	logic                              decide;
	logic                              tx_bit;
	logic                              sdo_q;
	logic                              oe_q;
	logic                              fifo_pop;
	logic [SMP_W-1:0]                  fifo_data;
	logic                              fifo_valid;

	// ------------------------------------------------------------
	// Sample buffer
	// ------------------------------------------------------------
	sarsr_fifo #(
		.WIDTH (SMP_W),
		.DEPTH (DEPTH)
	) u_fifo (
		.core_clk  (core_clk),
		.nrst      (nrst),
		.in_data   (smp_data),
		.in_valid  (smp_valid),
		.in_ready  (smp_ready),
		.out_data  (fifo_data),
		.out_valid (fifo_valid),
		.out_ready (fifo_pop)
	);

	// ------------------------------------------------------------
	// Link edge detection
	// ------------------------------------------------------------
	// Previous levels of select and serial clock
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			sel_prev_q  <= 1'b1;
			sclk_prev_q <= 1'b1;
		end else begin
			sel_prev_q  <= link.conv_sel_n;
			sclk_prev_q <= link.sclk;
		end
	end

	assign sel_fall  = sel_prev_q && !link.conv_sel_n;
	assign sel_rise  = !sel_prev_q && link.conv_sel_n;
	assign sclk_fall = sclk_prev_q && !link.sclk && !link.conv_sel_n;
	assign fifo_pop  = sel_fall && fifo_valid;

	// ------------------------------------------------------------
	// Frame control
	// ------------------------------------------------------------
	// Next state
	always_comb begin
		st_d = st_q;
		case (st_q)
			ST_IDLE: begin
				if (sel_fall) begin
					st_d = ST_SHIFT;
				end
			end
			ST_SHIFT: begin
				if (link.conv_sel_n) begin
					st_d = ST_IDLE;
				end else if (sclk_fall && cnt_q == sarsr_pkg::CNT_LAST) begin
					st_d = ST_DONE;
				end
			end
			ST_DONE: begin
				if (link.conv_sel_n) begin
					st_d = ST_IDLE;
				end
			end
			default: begin
				st_d = ST_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			st_q <= ST_IDLE;
		end else begin
			st_q <= st_d;
		end
	end

	// Bit counter, one step per serial clock fall
	assign cnt_next = cnt_q + sarsr_pkg::CNT_ONE;

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			cnt_q <= sarsr_pkg::CNT_ZERO;
		end else if (st_q == ST_IDLE) begin
			cnt_q <= sarsr_pkg::CNT_ZERO;
		end else if (st_q == ST_SHIFT && sclk_fall) begin
			cnt_q <= cnt_next;
		end
	end

	// ------------------------------------------------------------
	// Successive approximation
	// ------------------------------------------------------------
	// Bit under trial, MSB first after the lead zeros
	// First decided fall tries the MSB; shifts past the code clear the mask
	assign bit_mask = sarsr_pkg::CODE_SIGN >> (cnt_next - sarsr_pkg::CNT_LEAD);
	assign trial    = sar_q | bit_mask;
	assign decide   = (target_q >= trial);
	// Sign bit is the inverted offset MSB
	assign tx_bit   = (bit_mask == sarsr_pkg::CODE_SIGN) ? !decide : decide;

	// Sampled target, held in offset binary
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			target_q <= sarsr_pkg::CODE_SIGN;
		end else if (sel_fall) begin
			target_q <= (fifo_valid ? sat_code(fifo_data) : sarsr_pkg::CODE_ZERO)
				^ sarsr_pkg::CODE_SIGN;
		end
	end

	// Approximation register, cleared at select fall, otherwise moves only on clock falls
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			sar_q <= sarsr_pkg::CODE_ZERO;
		end else if (sel_fall) begin
			sar_q <= sarsr_pkg::CODE_ZERO;
		end else if (st_q == ST_SHIFT && sclk_fall && cnt_next >= sarsr_pkg::CNT_LEAD) begin
			if (decide) begin
				sar_q <= trial;
			end
		end
	end

	// ------------------------------------------------------------
	// Result pin
	// ------------------------------------------------------------
	// Data value: zeros first, then decided bits
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			sdo_q <= 1'b0;
		end else if (sel_fall) begin
			sdo_q <= 1'b0;
		end else if (st_q == ST_SHIFT && sclk_fall) begin
			if (cnt_next < sarsr_pkg::CNT_LEAD) begin
				sdo_q <= 1'b0;
			end else begin
				sdo_q <= tx_bit;
			end
		end
	end

	// Enable: on at select fall, off when deselected or done
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			oe_q <= 1'b0;
		end else if (sel_fall) begin
			oe_q <= 1'b1;
		end else if (link.conv_sel_n) begin
			oe_q <= 1'b0;
		end else if (st_q == ST_SHIFT && sclk_fall && cnt_q == sarsr_pkg::CNT_LAST) begin
			oe_q <= 1'b0;
		end
	end

	assign link.serial_result_out = sdo_q;
	assign link.serial_result_oe  = oe_q;

	// ------------------------------------------------------------
	// Local status
	// ------------------------------------------------------------
	// Completed code, with a one-cycle flag
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			code_q       <= sarsr_pkg::CODE_ZERO;
			code_valid_q <= 1'b0;
		end else begin
			code_valid_q <= 1'b0;
			if (st_q == ST_SHIFT && st_d == ST_DONE) begin
				code_q       <= (decide ? trial : sar_q) ^ sarsr_pkg::CODE_SIGN;
				code_valid_q <= 1'b1;
			end
		end
	end

	// Frame cut short, and start without a buffered sample
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			abort_q    <= 1'b0;
			underrun_q <= 1'b0;
		end else begin
			abort_q    <= (st_q == ST_SHIFT) && sel_rise;
			underrun_q <= sel_fall && !fifo_valid;
		end
	end

endmodule

// ### hdl/sarsr_fifo.sv
// Purpose: Sample buffer with valid and ready on both sides
// Assumes: Depth is a power of two
// Notes:   Pointers carry one extra bit for full and empty

`timescale 1ns/1ps

module sarsr_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input  wire logic             core_clk,
	input  wire logic             nrst,
	// Filling side
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	// Draining side
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wptr_q;
	logic [AW:0]      rptr_q;
	logic             push;
	logic             pop;

	// Full and empty from pointer compare
	assign in_ready  = !((wptr_q[AW] != rptr_q[AW]) && (wptr_q[AW-1:0] == rptr_q[AW-1:0]));
	assign out_valid = (wptr_q != rptr_q);
	assign out_data  = mem[rptr_q[AW-1:0]];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// Storage write
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[wptr_q[AW-1:0]] <= in_data;
		end
	end

	// Write pointer
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			wptr_q <= '0;
		end else if (push) begin
			wptr_q <= wptr_q + 1'b1;
		end
	end

	// Read pointer
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rptr_q <= '0;
		end else if (pop) begin
			rptr_q <= rptr_q + 1'b1;
		end
	end

endmodule

// ### hdl/sarsr_host.sv
// Purpose: Host end: drives select and serial clock, gathers result
// Assumes: Serial clock made from core_clk by a divider
// Notes:   Result sampled as each serial clock falls

`timescale 1ns/1ps

module sarsr_host #(
	parameter int HALF_CYC  = sarsr_pkg::HALF_CYC,
	parameter int SETUP_CYC = sarsr_pkg::SETUP_CYC,
	parameter int QUIET_CYC = sarsr_pkg::QUIET_CYC
) (
	// Clock and reset
	input  wire logic                           core_clk,
	input  wire logic                           nrst,
	// Link
	sarsr_link_if.host                          link,
	// Request and answer
	input  wire logic                           start,
	output logic                                busy_q,
	output logic signed [sarsr_pkg::CODE_W-1:0] result_q,
	output logic                                result_valid_q
);

	typedef enum logic [1:0] {
		HS_IDLE  = 2'b00,
		HS_SETUP = 2'b01,
		HS_RUN   = 2'b10,
		HS_QUIET = 2'b11
	} sarsr_host_st_t;

	localparam int TW = 8;

	sarsr_host_st_t                   st_q;
	logic [TW-1:0]                    tmr_q;
	logic [sarsr_pkg::CNT_W-1:0]      nfall_q;
	logic                             sel_n_q;
	logic                             sclk_q;
	logic [sarsr_pkg::FRAME_BITS-1:0] shreg_q;
	logic                             tmr_done;

	assign tmr_done = (tmr_q == '0);

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	// Select framing, clock divider and quiet gap
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			st_q    <= HS_IDLE;
			tmr_q   <= '0;
			nfall_q <= sarsr_pkg::CNT_ZERO;
			sel_n_q <= 1'b1;
			sclk_q  <= 1'b1;
		end else begin
			case (st_q)
				HS_IDLE: begin
					if (start) begin
						sel_n_q <= 1'b0;
						tmr_q   <= TW'(SETUP_CYC - 1);
						st_q    <= HS_SETUP;
					end
				end
				HS_SETUP: begin
					if (tmr_done) begin
						st_q  <= HS_RUN;
						tmr_q <= TW'(HALF_CYC - 1);
					end else begin
						tmr_q <= tmr_q - 1'b1;
					end
				end
				HS_RUN: begin
					if (!tmr_done) begin
						tmr_q <= tmr_q - 1'b1;
					end else if (sclk_q) begin
						sclk_q  <= 1'b0;
						nfall_q <= nfall_q + sarsr_pkg::CNT_ONE;
						tmr_q   <= TW'(HALF_CYC - 1);
					end else if (nfall_q == sarsr_pkg::FRAME_BITS[sarsr_pkg::CNT_W-1:0]) begin
						sclk_q  <= 1'b1;
						sel_n_q <= 1'b1;
						nfall_q <= sarsr_pkg::CNT_ZERO;
						tmr_q   <= TW'(QUIET_CYC - 1);
						st_q    <= HS_QUIET;
					end else begin
						sclk_q <= 1'b1;
						tmr_q  <= TW'(HALF_CYC - 1);
					end
				end
				HS_QUIET: begin
					if (tmr_done) begin
						st_q <= HS_IDLE;
					end else begin
						tmr_q <= tmr_q - 1'b1;
					end
				end
				default: begin
					st_q <= HS_IDLE;
				end
			endcase
		end
	end

	assign link.conv_sel_n = sel_n_q;
	assign link.sclk       = sclk_q;

	// ------------------------------------------------------------
	// Receive
	// ------------------------------------------------------------
	// Capture the standing bit as the clock is driven low
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			shreg_q <= '0;
		end else if (st_q == HS_RUN && tmr_done && sclk_q) begin
			shreg_q <= {shreg_q[sarsr_pkg::FRAME_BITS-2:0], link.serial_result_out};
		end
	end

	// Result taken as signed after the frame
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			result_q       <= '0;
			result_valid_q <= 1'b0;
			busy_q         <= 1'b0;
		end else begin
			result_valid_q <= (st_q == HS_RUN) && sel_n_q == 1'b0 && tmr_done && !sclk_q
				&& nfall_q == sarsr_pkg::FRAME_BITS[sarsr_pkg::CNT_W-1:0];
			if (st_q == HS_QUIET && tmr_q == TW'(QUIET_CYC - 1)) begin
				result_q <= signed'(shreg_q[sarsr_pkg::CODE_W-1:0]);
			end
			busy_q <= (st_q != HS_IDLE) || start;
		end
	end

endmodule

// ### hdl/sarsr_link_if.sv
// Purpose: Serial link between host and converter ends
// Assumes: Both ends run on the same core clock
// Notes:   Data pin carries value plus output enable

`timescale 1ns/1ps

interface sarsr_link_if;

	// Select, active low, from host
	logic conv_sel_n;
	// Serial clock, from host
	logic sclk;
	// Result pin and its enable, from device
	logic serial_result_out;
	logic serial_result_oe;

	// ------------------------------------------------------------
	// Party views
	// ------------------------------------------------------------
	modport dev  (input conv_sel_n, input sclk, output serial_result_out, output serial_result_oe);
	modport host (output conv_sel_n, output sclk, input serial_result_out, input serial_result_oe);

endinterface

// ### hdl/sarsr_pkg.sv
// Purpose: Shared constants for the converter serial readout ends
// Assumes: One core clock of 200 MHz on both ends
// Notes:   Times in ns, cycle counts derived from them

package sarsr_pkg;

	// ------------------------------------------------------------
	// Clock and link timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS   = 5;
	localparam int QUIET_NS        = 60;   // Least gap after a read
	localparam int SETUP_NS        = 10;   // Select fall to first clock fall
	localparam int SCLK_PERIOD_NS  = 100;  // Serial clock, 10 MHz
	// Least times round up, none below one cycle
	localparam int QUIET_CYC = (QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HALF_CYC  = (SCLK_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ------------------------------------------------------------
	// Frame layout
	// ------------------------------------------------------------
	localparam int CODE_W     = 12;
	localparam int LEAD_ZEROS = 4;
	localparam int FRAME_BITS = 16;
	localparam int CNT_W      = 5;
	localparam int SMP_W      = 16;   // Differential input, in LSB units
	localparam int FIFO_DEPTH = 16;

	// Code limits, twos complement
	localparam logic [CODE_W-1:0] CODE_MAX  = 12'h7ff;
	localparam logic [CODE_W-1:0] CODE_MIN  = 12'h800;
	localparam logic [CODE_W-1:0] CODE_SIGN = 12'h800;
	localparam logic [CODE_W-1:0] CODE_ZERO = 12'h000;

	// Frame position constants
	localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
	localparam logic [CNT_W-1:0] CNT_ONE  = 5'h01;
	localparam logic [CNT_W-1:0] CNT_LAST = 5'h0f;
	localparam logic [CNT_W-1:0] CNT_LEAD = 5'h04;
	localparam logic [CNT_W-1:0] CNT_TOP  = 5'h0f;  // Index of result MSB plus lead

endpackage

// ### tb/sarsr_asserts.sv
// Purpose: Wire checks on the link between host and converter ends
// Assumes: Both ends share core_clk, nrst is asynchronous active low
// Notes:   Takes the link signals as plain inputs, no bind

`timescale 1ns/1ps

module sarsr_asserts #(
	parameter int QUIET_CYC = sarsr_pkg::QUIET_CYC
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// Link
	input wire logic conv_sel_n,
	input wire logic sclk,
	input wire logic serial_result_out,
	input wire logic serial_result_oe
);

	logic       sclk_q;
	logic [4:0] fall_cnt_q;
	logic [7:0] high_cnt_q;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!nrst);

	// ------------------------------------------------------------
	// Helper counters
	// ------------------------------------------------------------
	// Last serial clock level, idles high
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) sclk_q <= 1'b1;
		else       sclk_q <= sclk;
	end

	// Serial clock falls inside the current frame
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst)                fall_cnt_q <= 5'h00;
		else if (conv_sel_n)      fall_cnt_q <= 5'h00;
		else if (sclk_q && !sclk) fall_cnt_q <= fall_cnt_q + 5'h01;
	end

	// Cycles with select high, saturating, counted full after reset
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst)                    high_cnt_q <= 8'hff;
		else if (!conv_sel_n)         high_cnt_q <= 8'h00;
		else if (high_cnt_q != 8'hff) high_cnt_q <= high_cnt_q + 8'h01;
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	AST_SEL_DRIVES_PIN: assert property (
		$fell(conv_sel_n) |-> ##[1:2] (serial_result_oe && !serial_result_out))
		else $error("pin not driven low after select fell");
	AST_RELEASE_IDLE: assert property (
		conv_sel_n && $past(conv_sel_n) && $past(conv_sel_n, 2) |-> !serial_result_oe)
		else $error("pin driven while deselected");
	AST_LEAD_ZEROS: assert property (
		serial_result_oe && !conv_sel_n && fall_cnt_q <= 5'h03 |-> !serial_result_out)
		else $error("leading bit not zero");
	AST_CHANGE_ON_FALL: assert property (
		serial_result_oe && $past(serial_result_oe) && $changed(serial_result_out)
		|-> !$past(sclk) || !$past(sclk, 2))
		else $error("result bit changed without a clock fall");
	AST_STEADY_HIGH: assert property (
		(sclk && serial_result_oe) [*4] |-> $stable(serial_result_out))
		else $error("result bit moved while clock high");
	AST_FRAME_END: assert property (
		fall_cnt_q == 5'h10 && !conv_sel_n |-> ##[1:3] !serial_result_oe)
		else $error("pin not released after sixteenth fall");
	AST_SIXTEEN_FALLS: assert property (
		!conv_sel_n |-> fall_cnt_q <= 5'h10)
		else $error("more than sixteen clock falls in a frame");
	AST_QUIET_GAP: assert property (
		$fell(conv_sel_n) |-> high_cnt_q >= QUIET_CYC)
		else $error("select fell before quiet gap ended");
	AST_SETUP_FALL: assert property (
		$fell(sclk) |-> !conv_sel_n && !$past(conv_sel_n, 2))
		else $error("clock fell without select setup");
	AST_CLK_IDLE: assert property (
		conv_sel_n && $past(conv_sel_n) |-> sclk)
		else $error("serial clock low outside frame");

endmodule

// ### tb/sarsr_bench.sv
// Purpose: Self-checking bench for host and converter ends together
// Assumes: 200 MHz core clock, inputs driven on the falling edge
// Notes:   A second converter on a bench-driven link takes rule breaks

`timescale 1ns/1ps

module sarsr_bench;

	localparam int HALF = 4;

	logic               core_clk;
	logic               nrst;
	logic signed [15:0] smp_data;
	logic               smp_valid;
	logic               smp_ready;
	logic [11:0]        code_q;
	logic               code_valid_q;
	logic               underrun_q;
	logic               abort2_q;
	logic               start;
	logic               busy_q;
	logic signed [11:0] result_q;
	logic               result_valid_q;
	logic               saw_under;
	int                 failures;
	int                 n_compared;

	sarsr_link_if link ();
	sarsr_link_if link2 ();
	// Resolved result pin, floats when released
	wire serial_wire = link.serial_result_oe ? link.serial_result_out : 1'bz;

	// ------------------------------------------------------------
	// Ends under test
	// ------------------------------------------------------------
	sarsr_dev sarsr_dev_i (.core_clk(core_clk), .nrst(nrst), .link(link), .smp_data(smp_data),
		.smp_valid(smp_valid), .smp_ready(smp_ready), .code_q(code_q), .code_valid_q(code_valid_q),
		.abort_q(), .underrun_q(underrun_q));
	sarsr_host #(.HALF_CYC(HALF)) sarsr_host_i (.core_clk(core_clk), .nrst(nrst), .link(link),
		.start(start), .busy_q(busy_q), .result_q(result_q), .result_valid_q(result_valid_q));
	sarsr_dev sarsr_dev2_i (.core_clk(core_clk), .nrst(nrst), .link(link2), .smp_data(16'h0000),
		.smp_valid(1'b0), .smp_ready(), .code_q(), .code_valid_q(), .abort_q(abort2_q),
		.underrun_q());
	sarsr_asserts sarsr_asserts_i (.core_clk(core_clk), .nrst(nrst), .conv_sel_n(link.conv_sel_n),
		.sclk(link.sclk), .serial_result_out(link.serial_result_out),
		.serial_result_oe(link.serial_result_oe));

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	// Compare and count
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Offer one sample for one falling edge
	task automatic push(input logic [15:0] v);
		smp_data = v;
		smp_valid = 1'b1;
		@(negedge core_clk);
		smp_valid = 1'b0;
	endtask

	// One conversion: gather wire bits on each clock fall, check all views
	task automatic convert(input logic [11:0] exp);
		logic [15:0] frame;
		logic        prev;
		int          n;
		int          nv;
		check(16'(serial_wire), 16'(1'bz));
		nv = 0;
		start = 1'b1;
		@(negedge core_clk);
		start = 1'b0;
		prev = link.sclk;
		frame = 16'h0000;
		n = 0;
		saw_under = 1'b0;
		while (!result_valid_q && n < 2000) begin
			@(negedge core_clk);
			if (prev && !link.sclk && !link.conv_sel_n) frame = {frame[14:0], serial_wire};
			prev = link.sclk;
			saw_under = saw_under | underrun_q;
			if (code_valid_q) nv++;
			n++;
		end
		@(negedge core_clk);
		check(16'(nv), 16'h0001);
		check(frame, {4'h0, exp});
		check({4'h0, result_q}, {4'h0, exp});
		check({4'h0, code_q}, {4'h0, exp});
		while (busy_q && n < 2000) begin
			@(negedge core_clk);
			n++;
		end
		if (n >= 2000) begin
			failures++;
			print_verdict;
		end
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	// Zero, both ends of range and clamping
	task automatic t_codes;
		logic [15:0] ins [8];
		logic [11:0] outs [8];
		ins = '{16'h0000, 16'hffff, 16'h07ff, 16'h07fe, 16'hf800, 16'hf801, 16'h1388, 16'hec78};
		outs = '{12'h000, 12'hfff, 12'h7ff, 12'h7fe, 12'h800, 12'h801, 12'h7ff, 12'h800};
		for (int i = 0; i < 8; i++) begin
			push(ins[i]);
			convert(outs[i]);
		end
	endtask

	// Fill buffer until refused, drain in order, then run empty
	task automatic t_fill;
		for (int i = 0; i < 16; i++) push(16'(i) - 16'h0008);
		check(16'(smp_ready), 16'h0000);
		smp_data = 16'h0123;
		smp_valid = 1'b1;
		repeat (3) @(negedge core_clk);
		smp_valid = 1'b0;
		for (int i = 0; i < 16; i++) convert(12'(i) - 12'h008);
		convert(12'h000);
		check(16'(saw_under), 16'h0001);
	endtask

	// Bench link: select raised mid-frame, then clocks while deselected
	task automatic t_abort;
		logic got;
		got = 1'b0;
		link2.conv_sel_n = 1'b0;
		repeat (3) @(negedge core_clk);
		check(16'(link2.serial_result_oe), 16'h0001);
		for (int i = 0; i < 10; i++) begin
			if (i == 6) link2.conv_sel_n = 1'b1;
			link2.sclk = 1'b0;
			// Abort flag stands one cycle, so look on every edge
			repeat (HALF) begin
				@(negedge core_clk);
				got = got | abort2_q;
			end
			link2.sclk = 1'b1;
			repeat (HALF) begin
				@(negedge core_clk);
				got = got | abort2_q;
			end
		end
		check(16'(got), 16'h0001);
		check(16'(link2.serial_result_oe), 16'h0000);
	endtask

	// ------------------------------------------------------------
	// Run control
	// ------------------------------------------------------------
	// Verdict and end of run
	task automatic print_verdict;
		if (failures == 0 && n_compared > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	// Clock
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	// Main sequence
	initial begin
		failures = 0;
		n_compared = 0;
		nrst = 1'b0;
		start = 1'b0;
		smp_valid = 1'b0;
		smp_data = 16'h0000;
		link2.conv_sel_n = 1'b1;
		link2.sclk = 1'b1;
		repeat (20) @(negedge core_clk);
		nrst = 1'b1;
		@(negedge core_clk);
		check({15'h0000, busy_q}, 16'h0000);
		t_codes;
		t_fill;
		t_abort;
		print_verdict;
	end

	// Watchdog, about five times the expected run
	initial begin
		repeat (20000) @(posedge core_clk);
		failures++;
		print_verdict;
	end

endmodule
